// >>> hw/smb_consts.vh
// Constants for the two-wire management bus slave port
`ifndef SMB_CONSTS_VH
`define SMB_CONSTS_VH

// ----------------------------------------
// Slave addresses
// ----------------------------------------
`define SMB_ADDR_DEFAULT 7'h2E
`define SMB_ADDR_SEL_LL  7'h2C
`define SMB_ADDR_SEL_LH  7'h2D

// ----------------------------------------
// Byte framing
// ----------------------------------------
`define SMB_DATA_BITS    4'h8
`define SMB_ACK_BIT      4'h9
`define SMB_ADDR_BITS    4'h7
`define SMB_WR_MAX       2'h2

// ----------------------------------------
// Configuration register
// ----------------------------------------
`define SMB_CFG_ADDR     8'h40
`define SMB_CFG_MON_BIT  0
`define SMB_CFG_LOCK_BIT 1
`define SMB_CFG_RST      8'h01

// ----------------------------------------
// Power-up strap capture
// ----------------------------------------
`define SMB_STRAP_WAIT   2'h2

`endif

// >>> hw/smb_slave.v
// Management bus slave port with address pointer and register file

`include "smb_consts.vh"

module smb_slave #(
    parameter ADDR_SELECTABLE = 0
) (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_n,
    input  wire       address_strap_enable,
    input  wire       addr_select_pin,
    input  wire       addr_second_strap,
    output reg  [6:0] slave_addr,
    output reg        addr_frozen,
    output reg  [7:0] addr_pointer,
    output reg        reg_wr_strobe,
    output reg  [7:0] reg_wr_addr,
    output reg  [7:0] reg_wr_data,
    output wire       monitor_enable,
    output wire       config_locked
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam NSYNC = 5;

    wire [NSYNC-1:0] pin_raw;
    reg  [NSYNC-1:0] pin_meta;
    reg  [NSYNC-1:0] pin_sync;

    assign pin_raw = {addr_second_strap, addr_select_pin,
                      address_strap_enable, sda_in, scl_in};

    // Two flops per pin before any logic reads it
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk) begin
                if (srst) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // Synchronised bus lines
    wire scl_s = pin_sync[0];
    wire sda_s = pin_sync[1];

    // ----------------------------------------
    // Bus event detection
    // ----------------------------------------
    reg scl_d;
    reg sda_d;

    // Previous levels for edge finding
    always @(posedge sys_clk) begin
        if (srst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------
    // Strap capture and address choice
    // ----------------------------------------
    reg       strap_taken;
    reg [1:0] strap_wait;
    reg       strap_en;
    reg       strap_sel;
    reg       strap_second;
    reg [6:0] sel_addr;

    // Straps caught once, after the synchronisers have flushed
    always @(posedge sys_clk) begin
        if (srst) begin
            strap_taken  <= 1'b0;
            strap_wait   <= 2'h0;
            strap_en     <= 1'b1;
            strap_sel    <= 1'b1;
            strap_second <= 1'b0;
        end else if (!strap_taken) begin
            // Sync flops still show their reset level for two edges
            if (strap_wait == `SMB_STRAP_WAIT) begin
                strap_taken  <= 1'b1;
                strap_en     <= pin_sync[2];
                strap_sel    <= pin_sync[3];
                strap_second <= pin_sync[4];
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    // Address from variant and straps
    always @* begin
        sel_addr = `SMB_ADDR_DEFAULT;
        if (ADDR_SELECTABLE != 0 && !strap_en && !strap_sel) begin
            if (strap_second)
                sel_addr = `SMB_ADDR_SEL_LH;
            else
                sel_addr = `SMB_ADDR_SEL_LL;
        end
    end

    // ----------------------------------------
    // Transfer engine
    // ----------------------------------------
    // Transfer states, binary coded
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_WRX  = 3'h2;
    localparam [2:0] ST_TX   = 3'h3;
    localparam [2:0] ST_IGN  = 3'h4;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx_shift;
    reg [7:0] tx_shift;
    reg [1:0] wr_cnt;
    reg       sda_drive;
    reg [7:0] cfg_reg;
    reg [7:0] reg_file [0:255];
    reg [7:0] rd_byte;
    reg [7:0] next_cfg;
    reg [6:0] cur_addr;

    // Slave address carried by the first byte
    wire addr_match = (rx_shift[7:1] == cur_addr);

    // Open drain: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~sda_drive;
    assign monitor_enable = cfg_reg[`SMB_CFG_MON_BIT];
    assign config_locked  = cfg_reg[`SMB_CFG_LOCK_BIT];

    // Address compared before and after freezing
    always @* begin
        cur_addr = addr_frozen ? slave_addr : sel_addr;
    end

    // Byte returned for a read at the pointer
    always @* begin
        if (addr_pointer == `SMB_CFG_ADDR)
            rd_byte = cfg_reg;
        else
            rd_byte = reg_file[addr_pointer];
    end

    // Configuration write with lock protection
    always @* begin
        next_cfg = rx_shift;
        if (cfg_reg[`SMB_CFG_LOCK_BIT]) begin
            next_cfg = cfg_reg;
            next_cfg[`SMB_CFG_MON_BIT] = rx_shift[`SMB_CFG_MON_BIT];
        end
    end

    // Register file storage, no reset
    always @(posedge sys_clk) begin
        if (reg_wr_strobe && reg_wr_addr != `SMB_CFG_ADDR)
            reg_file[reg_wr_addr] <= reg_wr_data;
    end

    // Protocol state machine
    always @(posedge sys_clk) begin
        if (srst) begin
            state         <= ST_IDLE;
            bit_cnt       <= 4'h0;
            rx_shift      <= 8'h00;
            tx_shift      <= 8'h00;
            wr_cnt        <= 2'h0;
            sda_drive     <= 1'b0;
            addr_pointer  <= 8'h00;
            slave_addr    <= `SMB_ADDR_DEFAULT;
            addr_frozen   <= 1'b0;
            reg_wr_strobe <= 1'b0;
            reg_wr_addr   <= 8'h00;
            reg_wr_data   <= 8'h00;
            cfg_reg       <= `SMB_CFG_RST;
        end else begin
            reg_wr_strobe <= 1'b0;
            if (bus_start) begin
                // Start or repeated start opens a new operation
                state     <= ST_ADDR;
                bit_cnt   <= 4'h0;
                wr_cnt    <= 2'h0;
                sda_drive <= 1'b0;
            end else if (bus_stop) begin
                state     <= ST_IDLE;
                bit_cnt   <= 4'h0;
                sda_drive <= 1'b0;
            end else if (scl_rise && state != ST_IDLE) begin
                // Sample data bits on rising clock
                if (bit_cnt < `SMB_DATA_BITS)
                    rx_shift <= {rx_shift[6:0], sda_s};
                if (state == ST_ADDR && bit_cnt == `SMB_ADDR_BITS &&
                    !addr_frozen && rx_shift[6:0] == sel_addr) begin
                    addr_frozen <= 1'b1;
                    slave_addr  <= sel_addr;
                end
                if (state == ST_TX && bit_cnt == `SMB_DATA_BITS)
                    state <= ST_IGN;
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == `SMB_DATA_BITS) begin
                            if (addr_match)
                                sda_drive <= 1'b1;
                            else
                                state <= ST_IGN;
                        end else if (bit_cnt == `SMB_ACK_BIT) begin
                            bit_cnt <= 4'h0;
                            if (rx_shift[0]) begin
                                // Read: first data bit goes out now
                                state     <= ST_TX;
                                tx_shift  <= rd_byte;
                                sda_drive <= ~rd_byte[7];
                            end else begin
                                state     <= ST_WRX;
                                sda_drive <= 1'b0;
                            end
                        end
                    end
                    ST_WRX: begin
                        if (bit_cnt == `SMB_DATA_BITS) begin
                            if (wr_cnt < `SMB_WR_MAX) begin
                                sda_drive <= 1'b1;
                                wr_cnt    <= wr_cnt + 2'h1;
                                if (wr_cnt == 2'h0) begin
                                    addr_pointer <= rx_shift;
                                end else begin
                                    reg_wr_strobe <= 1'b1;
                                    reg_wr_addr   <= addr_pointer;
                                    reg_wr_data   <= rx_shift;
                                    if (addr_pointer == `SMB_CFG_ADDR)
                                        cfg_reg <= next_cfg;
                                end
                            end else begin
                                // Third byte refused: no acknowledge
                                sda_drive <= 1'b0;
                            end
                        end else if (bit_cnt == `SMB_ACK_BIT) begin
                            sda_drive <= 1'b0;
                            bit_cnt   <= 4'h0;
                        end
                    end
                    ST_TX: begin
                        // Shift out the single read byte
                        if (bit_cnt < `SMB_DATA_BITS)
                            sda_drive <= ~tx_shift[3'h7 - bit_cnt[2:0]];
                        else
                            sda_drive <= 1'b0; // master drives acknowledge
                    end
                    ST_IGN: begin
                        sda_drive <= 1'b0;
                    end
                    default: begin
                        sda_drive <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // smb_slave

// >>> verif/smb_master_model.sv
// Bus master model making clock and data of the two-wire link
module smb_master_model (
    output logic scl,
    output logic sda_drv,
    input  wire  sda_wire
);
    timeunit 1ns;
    timeprecision 1ns;

    // Clock stands high, data released between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_drv = 1'b1;
        #250 scl = 1'b1;
        #200 sda_drv = 1'b0;
        #200 scl = 1'b0;
    endtask

    // Stop: data low in clock low, rises while clock high
    task automatic stop();
        #100 sda_drv = 1'b0;
        #200 scl = 1'b1;
        #200 sda_drv = 1'b1;
        #300;
    endtask

    // Eight bits MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            #100 sda_drv = (i == 0) ? 1'b1 : d[i-1];
            #200 scl = 1'b1;
            #50 if (i == 0) ack = sda_wire; else q[i-1] = sda_wire;
            #50 scl = 1'b0;
        end
    endtask
endmodule // smb_master_model

// >>> verif/smb_slave_properties.sv
// Concurrent checks on the bus slave port
module smb_slave_properties (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       scl_in,
    input wire logic       sda_oe_n,
    input wire logic [6:0] slave_addr,
    input wire logic       addr_frozen,
    input wire logic [7:0] addr_pointer,
    input wire logic       reg_wr_strobe,
    input wire logic [7:0] reg_wr_addr,
    input wire logic       monitor_enable,
    input wire logic       config_locked
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    strobe_one_cycle_a: assert property (reg_wr_strobe |=> !reg_wr_strobe)
        else $error("write strobe longer than one cycle");
    strobe_at_ptr_a: assert property (reg_wr_strobe |-> reg_wr_addr == addr_pointer)
        else $error("write address differs from pointer");
    addr_held_a: assert property (addr_frozen |=> addr_frozen && $stable(slave_addr))
        else $error("frozen address moved");
    addr_legal_a: assert property (slave_addr inside {7'h2C, 7'h2D, 7'h2E})
        else $error("slave address outside allowed set");
    lock_sticky_a: assert property (config_locked |=> config_locked)
        else $error("lock bit cleared");
    drive_match_a: assert property (!sda_oe_n |-> addr_frozen)
        else $error("data driven before address match");
    oe_clk_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while clock high");
    ptr_frozen_a: assert property ($changed(addr_pointer) |-> addr_frozen)
        else $error("pointer moved without a matched address");
    mon_write_a: assert property ($changed(monitor_enable) |->
        (reg_wr_strobe || $past(reg_wr_strobe)) && reg_wr_addr == 8'h40)
        else $error("monitor bit changed without a write");
endmodule // smb_slave_properties

// >>> verif/smb_slave_test.sv
// Self-checking bench for the bus slave port
module smb_slave_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       address_strap_enable = 1'b0;
    logic       addr_select_pin = 1'b0;
    logic       addr_second_strap = 1'b1;
    wire        scl_in, sda_m, sda_out, sda_oe_n, addr_frozen, reg_wr_strobe;
    wire        monitor_enable, config_locked;
    wire  [6:0] slave_addr;
    wire  [7:0] addr_pointer, reg_wr_addr, reg_wr_data;
    wire        sda_in = sda_m & (sda_oe_n | sda_out); // Pull-up wired-and
    int         fails = 0, comparisons = 0, cycles = 0, writes = 0, n;
    logic [7:0] q;
    logic       ack;

    smb_master_model mst_u (.scl(scl_in), .sda_drv(sda_m), .sda_wire(sda_in));
    smb_slave #(.ADDR_SELECTABLE(1)) dut_u (
        .sys_clk(sys_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_strap_enable(address_strap_enable), .addr_select_pin(addr_select_pin),
        .addr_second_strap(addr_second_strap), .slave_addr(slave_addr),
        .addr_frozen(addr_frozen), .addr_pointer(addr_pointer),
        .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .monitor_enable(monitor_enable),
        .config_locked(config_locked));

    initial forever #25 sys_clk = ~sys_clk;

    // Cycle count, write count and hang limit
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (reg_wr_strobe === 1'b1) writes <= writes + 1;
        if (cycles == 40000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic addr(input logic [6:0] a, input logic rd);
        mst_u.start();
        mst_u.xfer({a, rd}, q, ack);
    endtask

    task automatic wreg(input logic [7:0] p, input logic [7:0] d);
        addr(7'h2D, 1'b0);
        mst_u.xfer(p, q, ack);
        mst_u.xfer(d, q, ack);
        mst_u.stop();
    endtask

    task automatic test_address();
        @(negedge sys_clk);
        addr_select_pin = 1'b1;
        addr(7'h2E, 1'b0);
        chk(8'(ack), 8'h01);
        chk(8'(addr_frozen), 8'h00);
        mst_u.stop();
        addr(7'h2D, 1'b0);
        chk(8'(ack), 8'h00);
        chk(8'(slave_addr), 8'h2D);
        mst_u.xfer(8'h10, q, ack);
        mst_u.stop();
        chk(8'(ack), 8'h00);
        chk(addr_pointer, 8'h10);
        $display("test_address done");
    endtask

    task automatic test_write();
        addr(7'h2D, 1'b0);
        mst_u.xfer(8'h33, q, ack);
        mst_u.xfer(8'hA5, q, ack);
        chk(8'(ack), 8'h00);
        chk(reg_wr_addr, 8'h33);
        chk(reg_wr_data, 8'hA5);
        mst_u.xfer(8'h5A, q, ack);
        mst_u.stop();
        chk(8'(ack), 8'h01);
        $display("test_write done");
    endtask

    task automatic test_read();
        n = writes;
        wreg(8'h10, 8'h00);
        addr(7'h2D, 1'b0);
        mst_u.xfer(8'h33, q, ack);
        addr(7'h2D, 1'b1);
        mst_u.xfer(8'hFF, q, ack);
        mst_u.stop();
        chk(q, 8'hA5);
        chk(8'(writes - n), 8'h01);
        addr(7'h2D, 1'b1);
        mst_u.xfer(8'hFF, q, ack);
        mst_u.stop();
        chk(q, 8'hA5);
        $display("test_read done");
    endtask

    task automatic test_lock();
        wreg(8'h40, 8'h02);
        chk(8'({monitor_enable, config_locked}), 8'h01);
        wreg(8'h40, 8'h01);
        chk(8'({monitor_enable, config_locked}), 8'h03);
        wreg(8'h40, 8'h00);
        chk(8'({monitor_enable, config_locked}), 8'h01);
        $display("test_lock done");
    endtask

    // Mid-run reset with new strap levels, bus left idle
    task automatic reboot(input logic en, input logic sel, input logic sec);
        @(negedge sys_clk);
        address_strap_enable = en;
        addr_select_pin = sel;
        addr_second_strap = sec;
        srst = 1'b1;
        repeat (4) @(negedge sys_clk);
        srst = 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask

    task automatic test_straps();
        reboot(1'b1, 1'b0, 1'b0);
        addr(7'h2C, 1'b0);
        mst_u.stop();
        chk(8'(ack), 8'h01);
        addr(7'h2E, 1'b0);
        mst_u.stop();
        chk(8'(ack), 8'h00);
        chk(8'(addr_frozen), 8'h01);
        reboot(1'b0, 1'b0, 1'b0);
        chk(8'(addr_frozen), 8'h00);
        addr(7'h2D, 1'b0);
        mst_u.stop();
        chk(8'(ack), 8'h01);
        addr(7'h2C, 1'b0);
        mst_u.stop();
        chk(8'(ack), 8'h00);
        chk(8'(slave_addr), 8'h2C);
        reboot(1'b0, 1'b1, 1'b0);
        addr(7'h2E, 1'b0);
        mst_u.stop();
        chk(8'(ack), 8'h00);
        chk(8'(slave_addr), 8'h2E);
        $display("test_straps done");
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(negedge sys_clk);
        srst = 1'b0;
        repeat (10) @(negedge sys_clk);
        test_address();
        test_write();
        test_read();
        test_lock();
        test_straps();
        print_verdict();
    end
endmodule // smb_slave_test

bind smb_slave smb_slave_properties chk_u (
    .sys_clk(sys_clk), .srst(srst), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
    .slave_addr(slave_addr), .addr_frozen(addr_frozen), .addr_pointer(addr_pointer),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr),
    .monitor_enable(monitor_enable), .config_locked(config_locked));
